// File: rtl/dcbu_ctrl.sv
// control word bits D13..D6: half loads, select, source, reset, gating and DAC power-down
// Summary of operation
// - half-select 1 with full load off writes only upper 14 frequency bits.
// - half-select 0 with full load off writes only lower 14 bits.
// - half loads keep the other 14 bits unchanged; repeats allowed.
// - half-select is ignored while full-word load bit is 1.
// - frequency select bit chooses which frequency word feeds accumulator.
// - phase select bit chooses which phase offset is added.
// - source bit 1 takes selects, reset, DAC power-down from pins.
// - source bit 0 takes those functions from register bits.
// - reset bit acts only while source bit is 0.
// - reset clears internal registers to zero, giving midscale output.
// - reset bit 0 means normal operation.
// - clock-gate bit 1 stops internal clock; accumulator and output hold.
// - clock-gate bit 0 runs the internal clock normally.
// - control bits are sampled on the rising edge of clk_sys_i.
// - pin select changes take effect after eight clock cycles.
`timescale 1ns/1ps
module dcbu_ctrl
  import dcbu_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic [CW_W-1:0]   word_i,
  input  wire logic              word_we_i,
  input  wire logic              freq_we_i,
  input  wire logic              freq_addr_i,
  input  wire logic [HALF_W-1:0] freq_data_i,
  input  wire logic              freq_choice_pin_i,
  input  wire logic              phase_choice_pin_i,
  input  wire logic              reset_pin_i,
  input  wire logic              sleep_pin_i,
  output dcbu_ctrl_t             ctrl_o,
  output dcbu_eff_t              eff_o,
  output logic [FW_W-1:0]        freq_word_a_o,
  output logic [FW_W-1:0]        freq_word_b_o,
  output logic [FW_W-1:0]        freq_active_o,
  output logic                   acc_clk_en_o
);
  dcbu_ctrl_t        ctrl_q, ctrl_d;
  dcbu_eff_t         eff_q, eff_d;
  logic [FW_W-1:0]   fa_q, fa_d, fb_q, fb_d;
  logic [HALF_W-1:0] lsb_hold_q, lsb_hold_d;
  logic              lsb_pend_q, lsb_pend_d;
  logic [1:0]        pin_s1_q, pin_s2_q;
  logic [1:0]        pin_s1_d, pin_s2_d;
  logic [1:0]        rp_s1_q, rp_s2_q;
  logic [1:0]        rp_s1_d, rp_s2_d;
  logic [1:0]        sel_late;
  logic              word_take;

  // write one half of a frequency word; other half kept intact
  function automatic logic [FW_W-1:0] put_half(
    input logic [FW_W-1:0]   old,
    input logic [HALF_W-1:0] val,
    input logic              upper
  );
    logic [FW_W-1:0] r;
    r = old;
    if (upper) begin
      r[FW_W-1:HALF_W] = val;
    end else begin
      r[HALF_W-1:0] = val;
    end
    return r;
  endfunction

  // a word changes the control bits only when both top bits are clear;
  // any other word belongs to another register and is dropped silently
  function automatic logic ctrl_word_hit(
    input logic [CW_W-1:0] w
  );
    return !w[BIT_TOP1] && !w[BIT_TOP0];
  endfunction

  // next values of the synchronisers; sleep pin stands for DAC power-down
  always_comb begin
    pin_s1_d = {freq_choice_pin_i, phase_choice_pin_i};
    pin_s2_d = pin_s1_q;
    rp_s1_d  = {reset_pin_i, sleep_pin_i};
    rp_s2_d  = rp_s1_q;
  end

  // two-flop synchronisers for the pins; first flop read only by second
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      rp_s1_q  <= '0;
      rp_s2_q  <= '0;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      rp_s1_q  <= rp_s1_d;
      rp_s2_q  <= rp_s2_d;
    end
  end

  // pin selects travel the fixed pipeline; two sync flops, the pipeline
  // and the effective register add up to eight cycles from the pin edge.
  // a pin edge that misses the first flop's setup window costs one more
  // cycle, so the latency is eight or nine, never anything else
  dcbu_sel_delay u_sel_delay (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .d_i       (pin_s2_q),
    .q_o       (sel_late)
  );

  // strobe that lets a control word through to the control bits
  always_comb begin
    word_take = word_we_i && ctrl_word_hit(word_i);
  end

  // control word capture and frequency word loading
  always_comb begin
    ctrl_d     = ctrl_q;
    fa_d       = fa_q;
    fb_d       = fb_q;
    lsb_hold_d = lsb_hold_q;
    lsb_pend_d = lsb_pend_q;
    // only words with both top bits clear reach the control bits
    if (word_take) begin
      ctrl_d.full_word_load        = word_i[BIT_FULL];
      ctrl_d.freq_half_select      = word_i[BIT_HALF];
      ctrl_d.freq_reg_choice_bit   = word_i[BIT_FREQ_REG_CHOICE_BIT];
      ctrl_d.phase_reg_choice_bit  = word_i[BIT_PSEL];
      ctrl_d.control_source_select = word_i[BIT_SRC];
      ctrl_d.soft_reset            = word_i[BIT_RST];
      ctrl_d.internal_clock_gate   = word_i[BIT_GATE];
      ctrl_d.dac_power_down        = word_i[BIT_DACPD];
      lsb_pend_d                   = 1'b0;
    end
    if (freq_we_i) begin
      if (ctrl_q.full_word_load) begin
        // first write holds LSBs, second commits whole word at once
        // so the accumulator never sees a half-updated word; the
        // second write's address decides which word takes all 28 bits
        if (!lsb_pend_q) begin
          lsb_hold_d = freq_data_i;
          lsb_pend_d = 1'b1;
        end else begin
          lsb_pend_d = 1'b0;
          if (freq_addr_i) begin
            fb_d = {freq_data_i, lsb_hold_q};
          end else begin
            fa_d = {freq_data_i, lsb_hold_q};
          end
        end
      end else if (freq_addr_i) begin
        fb_d = put_half(fb_q, freq_data_i, ctrl_q.freq_half_select);
      end else begin
        fa_d = put_half(fa_q, freq_data_i, ctrl_q.freq_half_select);
      end
    end
    // reset clears internal frequency state to zero; a frequency write
    // in a reset cycle is lost, since reset must win
    if (eff_q.reset) begin
      fa_d       = '0;
      fb_d       = '0;
      lsb_pend_d = 1'b0;
    end
  end

  // effective controls: register bits or pins by source select
  always_comb begin
    if (ctrl_q.control_source_select) begin
      // register select and reset bits disregarded here
      eff_d.freq_sel  = sel_late[1];
      eff_d.phase_sel = sel_late[0];
      // reset and sleep pins skip the pipeline, only synchronised
      eff_d.reset     = rp_s2_q[1];
      eff_d.dac_pd    = rp_s2_q[0];
    end else begin
      eff_d.freq_sel  = ctrl_q.freq_reg_choice_bit;
      eff_d.phase_sel = ctrl_q.phase_reg_choice_bit;
      eff_d.reset     = ctrl_q.soft_reset;
      eff_d.dac_pd    = ctrl_q.dac_power_down;
    end
  end

  // effective controls registered on their own, one cycle after the bits
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eff_q <= '0;
    end else begin
      eff_q <= eff_d;
    end
  end

  // registers; the control bits are taken on one edge as a whole word
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q     <= '0;
      fa_q       <= '0;
      fb_q       <= '0;
      lsb_hold_q <= '0;
      lsb_pend_q <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      fa_q       <= fa_d;
      fb_q       <= fb_d;
      lsb_hold_q <= lsb_hold_d;
      lsb_pend_q <= lsb_pend_d;
    end
  end

  assign ctrl_o        = ctrl_q;
  assign eff_o         = eff_q;
  assign freq_word_a_o = fa_q;
  assign freq_word_b_o = fb_q;
  // active frequency word feeding the accumulator
  assign freq_active_o = eff_q.freq_sel ? fb_q : fa_q;
  // enable instead of a gated clock keeps one clock tree free of glitches;
  // reset also holds accumulator at zero
  assign acc_clk_en_o  = !ctrl_q.internal_clock_gate
                         && !eff_q.reset;
  // phase choice leaves on eff_o.phase_sel for the phase adder
endmodule

// File: rtl/dcbu_pkg.sv
// package: control word layout, frequency word layout and timing for dcbu
package dcbu_pkg;
  localparam int CW_W          = 16;
  localparam int FW_W          = 28;
  localparam int HALF_W        = 14;
  localparam int PW_W          = 12;
  // control word bit positions
  localparam int BIT_TOP1      = 15;
  localparam int BIT_TOP0      = 14;
  localparam int BIT_FULL      = 13;
  localparam int BIT_HALF      = 12;
  localparam int BIT_FREQ_REG_CHOICE_BIT      = 11;
  localparam int BIT_PSEL      = 10;
  localparam int BIT_SRC       = 9;
  localparam int BIT_RST       = 8;
  localparam int BIT_GATE      = 7;
  localparam int BIT_DACPD     = 6;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  // pin select latency in master clock cycles
  localparam int SEL_LAT       = 8;
  localparam logic [3:0] LAT_W4 = 4'(SEL_LAT - 1);
  // two sync flops and the effective register use part of the latency
  localparam int SYNC_STAGES   = 2;
  localparam int SEL_PIPE      = SEL_LAT - SYNC_STAGES - 1;

  typedef struct packed {
    logic full_word_load;
    logic freq_half_select;
    logic freq_reg_choice_bit;
    logic phase_reg_choice_bit;
    logic control_source_select;
    logic soft_reset;
    logic internal_clock_gate;
    logic dac_power_down;
  } dcbu_ctrl_t;

  typedef struct packed {
    logic freq_sel;
    logic phase_sel;
    logic reset;
    logic dac_pd;
  } dcbu_eff_t;
endpackage

// File: rtl/dcbu_sel_delay.sv
// fixed-length shift delay for the pin select lines
`timescale 1ns/1ps
module dcbu_sel_delay
  import dcbu_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic [1:0] d_i,
  output logic      [1:0] q_o
);
  logic [SEL_PIPE-1:0][1:0] pipe_q;
  logic [SEL_PIPE-1:0][1:0] pipe_d;

  // shift one stage per master clock; sync and output flops make up the rest
  always_comb begin
    pipe_d = {pipe_q[SEL_PIPE-2:0], d_i};
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= pipe_d;
    end
  end

  assign q_o = pipe_q[SEL_PIPE-1];
endmodule

// File: tb/dcbu_checker.sv
// checker: decode, half loads, frequency select, reset and gating
`timescale 1ns/1ps
module dcbu_checker
  import dcbu_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              rstn_i,
  input wire logic [CW_W-1:0]   word_i,
  input wire logic              word_we_i,
  input wire logic              freq_we_i,
  input wire logic              freq_addr_i,
  input wire logic [HALF_W-1:0] freq_data_i,
  input dcbu_ctrl_t             ctrl_o,
  input dcbu_eff_t              eff_o,
  input wire logic [FW_W-1:0]   freq_word_a_o,
  input wire logic [FW_W-1:0]   freq_word_b_o,
  input wire logic [FW_W-1:0]   freq_active_o,
  input wire logic              acc_clk_en_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // accepted control write, and a half write with no reset pending
  sequence s_take;
    word_we_i && word_i[15:14] == 2'b00;
  endsequence
  sequence s_half(up, ad);
    freq_we_i && !ctrl_o.full_word_load && freq_addr_i == ad
      && ctrl_o.freq_half_select == up && !eff_o.reset;
  endsequence
  AST_TAKE: assert property (s_take |=> ctrl_o == $past(word_i[13:6]))
    else $error("control bits not taken");
  AST_UP: assert property (s_half(1, 0) |=>
    freq_word_a_o == {$past(freq_data_i), $past(freq_word_a_o[13:0])})
    else $error("upper half load wrong");
  AST_LO: assert property (s_half(0, 1) |=>
    freq_word_b_o == {$past(freq_word_b_o[27:14]), $past(freq_data_i)})
    else $error("lower half load wrong");
  AST_FREQ_REG_CHOICE_BIT: assert property (!ctrl_o.control_source_select |=>
    eff_o.freq_sel == $past(ctrl_o.freq_reg_choice_bit))
    else $error("register frequency select not applied");
  AST_SRST: assert property (!ctrl_o.control_source_select |=>
    eff_o.reset == $past(ctrl_o.soft_reset))
    else $error("register reset not applied");
  AST_MUX: assert property (freq_active_o ==
    (eff_o.freq_sel ? freq_word_b_o : freq_word_a_o))
    else $error("active frequency word wrong");
  AST_ZERO: assert property (eff_o.reset |=>
    freq_word_a_o == '0 && freq_word_b_o == '0)
    else $error("reset did not clear words");
  AST_GATE: assert property (ctrl_o.internal_clock_gate |-> !acc_clk_en_o)
    else $error("accumulator ran while gated");
endmodule
bind dcbu_ctrl dcbu_checker chk (.clk_sys_i, .rstn_i, .word_i, .word_we_i,
  .freq_we_i, .freq_addr_i, .freq_data_i, .ctrl_o, .eff_o, .freq_word_a_o,
  .freq_word_b_o, .freq_active_o, .acc_clk_en_o);

// File: tb/dcbu_host.sv
// host model: writes control words and frequency halves
`timescale 1ns/1ps
module dcbu_host (
  input  wire logic        clk_sys_i,
  output logic      [15:0] word_o,
  output logic             wwe_o,
  output logic             fwe_o,
  output logic             addr_o,
  output logic      [13:0] data_o
);
  initial {word_o, wwe_o, fwe_o, addr_o, data_o} = '0;
  // one-cycle strobe; idle bus shows inverted data so stale bits never help
  task automatic send_word(input logic [15:0] w);
    @(negedge clk_sys_i) {wwe_o, word_o} <= {1'b1, w};
    @(negedge clk_sys_i) {wwe_o, word_o} <= {1'b0, ~w};
  endtask
  task automatic send_freq(input logic a, input logic [13:0] d);
    @(negedge clk_sys_i) {fwe_o, addr_o, data_o} <= {2'b10 | a, d};
    @(negedge clk_sys_i) {fwe_o, addr_o, data_o} <= {1'b0, ~a, ~d};
  endtask
endmodule

// File: tb/tb_dds_control_bits_upper.sv
// testbench: control decode, half loads, selects, pins, reset, gating
`timescale 1ns/1ps
module tb_dds_control_bits_upper import dcbu_pkg::*;;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [15:0] word;
  logic        wwe, fwe, addr, acc;
  logic [13:0] data;
  logic        fpin = 1'b0, ppin = 1'b0, rpin = 1'b0, spin = 1'b0;
  dcbu_ctrl_t  ctrl;
  dcbu_eff_t   eff;
  logic [27:0] fa, fb, fact;
  int          fails = 0, n_checks = 0, cyc = 0;
  dcbu_host host (.clk_sys_i, .word_o(word), .wwe_o(wwe), .fwe_o(fwe),
    .addr_o(addr), .data_o(data));
  dcbu_ctrl dut (.clk_sys_i, .rstn_i, .word_i(word), .word_we_i(wwe),
    .freq_we_i(fwe), .freq_addr_i(addr), .freq_data_i(data),
    .freq_choice_pin_i(fpin), .phase_choice_pin_i(ppin),
    .reset_pin_i(rpin), .sleep_pin_i(spin), .ctrl_o(ctrl), .eff_o(eff),
    .freq_word_a_o(fa), .freq_word_b_o(fb), .freq_active_o(fact),
    .acc_clk_en_o(acc));
  // 40 MHz master clock
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  task automatic chk(string n, logic [27:0] e, logic [27:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wt(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // watchdog: the whole run needs well under 400 cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end
  // half loads: upper a, lower a, lower b, repeated upper a
  task automatic t_half_loads;
    host.send_word(16'h1000);
    host.send_freq(1'b0, 14'h2abc);
    wt(1);
    chk("upper a", {14'h2abc, 14'h0000}, fa);
    host.send_word(16'h0000);
    host.send_freq(1'b0, 14'h1555);
    wt(1);
    chk("lower a", {14'h2abc, 14'h1555}, fa);
    host.send_freq(1'b1, 14'h0abc);
    wt(1);
    chk("lower b", {14'h0000, 14'h0abc}, fb);
    host.send_word(16'h1000);
    host.send_freq(1'b0, 14'h0001);
    host.send_freq(1'b0, 14'h0002);
    wt(1);
    chk("repeat upper a", {14'h0002, 14'h1555}, fa);
    $display("half loads done");
  endtask
  // full word pair to b, then a refused word
  task automatic t_full_load;
    host.send_word(16'h3000);
    host.send_freq(1'b1, 14'h0123);
    host.send_freq(1'b1, 14'h0456);
    wt(1);
    chk("full b", {14'h0456, 14'h0123}, fb);
    host.send_word(16'h4080);
    wt(1);
    chk("refused word", 28'h00000c0, ctrl);
    $display("full load done");
  endtask
  // register selects, DAC bit and clock gating
  task automatic t_select_gate;
    host.send_word(16'h0c40);
    wt(1);
    chk("selects", 28'h0000003, {eff.freq_sel, eff.phase_sel});
    chk("dac bit", 28'h0000001, eff.dac_pd);
    chk("active", {14'h0456, 14'h0123}, fact);
    host.send_word(16'h0080);
    wt(1);
    chk("gated", 28'h0000000, acc);
    host.send_word(16'h0000);
    wt(1);
    chk("running", 28'h0000001, acc);
    $display("selects and gating done");
  endtask
  // software reset clears both words, then a load works again
  task automatic t_soft_reset;
    host.send_word(16'h0100);
    wt(2);
    chk("reset", 28'h0000000, fa | fb | acc);
    host.send_word(16'h0000);
    host.send_freq(1'b0, 14'h0007);
    wt(2);
    chk("after reset", 28'h0000007, fa);
    $display("reset done");
  endtask
  // pin control: selects after eight cycles, reset and sleep pins
  task automatic t_pin_control;
    host.send_word(16'h0b00);
    wt(2);
    chk("pin mode bits", 28'h0000000, {eff.reset, eff.freq_sel});
    fpin = 1'b1;
    ppin = 1'b1;
    wt(7);
    chk("pin early", 28'h0, {eff.freq_sel, eff.phase_sel});
    wt(1);
    chk("pin late", 28'h3, {eff.freq_sel, eff.phase_sel});
    rpin = 1'b1;
    spin = 1'b1;
    wt(3);
    chk("pin reset sleep", 28'h6, {eff.reset, eff.dac_pd, acc});
    wt(1);
    chk("pin reset words", 28'h0, fa | fb);
    rpin = 1'b0;
    spin = 1'b0;
    wt(3);
    chk("pin reset off", 28'h1, {eff.reset, acc});
    $display("pin control done");
  endtask
  initial begin
    wt(8);
    rstn_i = 1'b1;
    t_half_loads();
    t_full_load();
    t_select_gate();
    t_soft_reset();
    t_pin_control();
    complete_run();
  end
endmodule
